// [shared/crf_map.svh]
// Register file widths, counts, reset values and index constants
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH
`define CRF_B_W 8
`define CRF_W_W 16
`define CRF_L_W 32
`define CRF_BANKS 2
`define CRF_NDATA 8
`define CRF_NADDR 4
`define CRF_PAIR_BIT 3'h2
`define CRF_BIT_ONE 8'h01
`define CRF_RST16 16'h0000
`define CRF_RST32 32'h00000000
`endif

// [shared/crf_pkg.sv]
// Types shared by the core register file and its users
`include "crf_map.svh"
package crf_pkg;
  typedef enum logic [3:0] {
    signed_quotient_op, unsigned_quotient_op, alt_sign_quotient_op,
    signed_product_op, unsigned_product_op,
    wide_signed_quotient_op, wide_unsigned_quotient_op,
    wide_alt_sign_quotient_op, wide_signed_product_op,
    wide_unsigned_product_op, bit_set_op, bit_clear_op
  } crf_op_e;
  typedef enum logic [2:0] {
    kind_data, kind_addr, kind_frame, kind_static, kind_flag
  } crf_kind_e;
  typedef enum logic [1:0] {
    size_low, size_high, size_word, size_long
  } crf_size_e;
  typedef struct packed {
    logic valid;
    crf_kind_e kind;
    logic [2:0] idx;
    crf_size_e size;
    logic [`CRF_L_W-1:0] data;
  } crf_wr_s;
  typedef struct packed {
    crf_kind_e kind;
    logic [2:0] idx;
    crf_size_e size;
  } crf_rd_s;
  typedef struct packed {
    logic valid;
    crf_op_e op;
    logic word;
    logic hi;
    logic [2:0] dst;
    logic [2:0] src;
    logic [2:0] bit_idx;
  } crf_ex_s;
endpackage

// [src/crf_core.sv]
// Banked general register file with multiply, divide and bit operations
// Summary of operation
// - Byte divide: 8 by 8 gives 8
// - Word divide: 16 by 16 gives 16
// - Byte multiply keeps only 8-bit result
// - Word multiply keeps only 16-bit result
// - Wide divide and multiply under extended opcodes
// - Bit index 0..7 on upper or lower half
// - Low data registers 16 bits, byte halves
// - Pairs two/zero and three/one form 32 bits
// - Registers four..seven; seven/five, six/four pair
// - Frame base register is 32 bits
// - Two banks of data, address, frame base
`timescale 1ns/1ps
`include "crf_map.svh"
module crf_core (
  input wire logic clock, // Core clock
  input wire logic rst, // Synchronous reset, high
  input wire logic bank_sel, // Register bank in use
  input wire crf_pkg::crf_wr_s wr, // Register write request
  output logic wr_ready, // Write accepted this cycle
  input wire crf_pkg::crf_rd_s rd, // Register read request
  output logic [`CRF_L_W-1:0] rd_data, // Read data, next cycle
  input wire crf_pkg::crf_ex_s ex, // Operation request
  output logic [`CRF_L_W-1:0] ex_result, // Pair upper and dest after op
  output logic ex_done, // Operation written back
  output logic ex_fault, // Zero divisor, overflow or bad pair destination
  output logic [`CRF_L_W-1:0] condition_word // Flag register
);
  // storage: two banks of eight data registers
  logic [`CRF_W_W-1:0] dreg [`CRF_BANKS][`CRF_NDATA];
  logic [`CRF_L_W-1:0] areg [`CRF_BANKS][`CRF_NADDR];
  logic [`CRF_L_W-1:0] frame_base_pointer [`CRF_BANKS];
  logic [`CRF_L_W-1:0] static_base_pointer;

  // Operand fetch
  wire [2:0] up_idx = ex.dst | `CRF_PAIR_BIT;
  wire [15:0] dst16 = dreg[bank_sel][ex.dst];
  wire [15:0] src16 = dreg[bank_sel][ex.src];
  wire [15:0] up16 = dreg[bank_sel][up_idx];
  wire [7:0] a8 = ex.hi ? dst16[15:8] : dst16[7:0];
  wire [7:0] b8 = ex.hi ? src16[15:8] : src16[7:0];

  // Operation classes
  wire is_wide = ex.op inside {crf_pkg::wide_signed_quotient_op,
    crf_pkg::wide_unsigned_quotient_op,
    crf_pkg::wide_alt_sign_quotient_op,
    crf_pkg::wide_signed_product_op, crf_pkg::wide_unsigned_product_op};
  wire is_alt = ex.op inside {crf_pkg::alt_sign_quotient_op,
    crf_pkg::wide_alt_sign_quotient_op};
  wire is_div = is_alt || ex.op inside {crf_pkg::signed_quotient_op,
    crf_pkg::unsigned_quotient_op, crf_pkg::wide_signed_quotient_op,
    crf_pkg::wide_unsigned_quotient_op};
  wire is_bit = ex.op inside {crf_pkg::bit_set_op, crf_pkg::bit_clear_op};
  wire is_sgn = is_alt || ex.op inside {crf_pkg::signed_quotient_op,
    crf_pkg::wide_signed_quotient_op, crf_pkg::signed_product_op,
    crf_pkg::wide_signed_product_op};

  // byte operands are extended to a common 16-bit width
  wire [15:0] a_n = ex.word ? dst16 : {{8{is_sgn & a8[7]}}, a8};
  wire [15:0] b_n = ex.word ? src16 : {{8{is_sgn & b8[7]}}, b8};
  // wide forms take a double-width dividend
  wire [15:0] dvd_lo = (is_wide && !ex.word) ? dst16 : a_n;
  wire [31:0] dvd32 = (is_wide && ex.word) ? {up16, dst16} :
    {{16{is_sgn & dvd_lo[15]}}, dvd_lo};
  wire [31:0] dvs32 = {{16{is_sgn & b_n[15]}}, b_n};
  wire dvs_zero = (dvs32 == `CRF_RST32);
  // Zero divisor is replaced so the divider never yields unknowns
  wire [31:0] dvs_safe = dvs_zero ? 32'h00000001 : dvs32;

  wire [31:0] sq = 32'($signed(dvd32) / $signed(dvs_safe));
  wire [31:0] sr = 32'($signed(dvd32) % $signed(dvs_safe));
  wire [31:0] uq = dvd32 / dvs_safe;
  wire [31:0] ur = dvd32 % dvs_safe;
  wire [31:0] q0 = is_sgn ? sq : uq;
  wire [31:0] r0 = is_sgn ? sr : ur;
  // Alternate sign: remainder takes the divisor's sign
  wire adj = is_alt && (r0 != `CRF_RST32) && (r0[31] != dvs32[31]);
  wire [31:0] q = adj ? q0 - 32'h00000001 : q0;
  wire [31:0] rem = adj ? r0 + dvs32 : r0;

  wire [31:0] q_sx8 = {{24{q[7]}}, q[7:0]};
  wire [31:0] q_sx16 = {{16{q[15]}}, q[15:0]};
  wire [31:0] q_ux8 = {24'h000000, q[7:0]};
  wire [31:0] q_ux16 = {16'h0000, q[15:0]};
  wire q_fit = ex.word ? (q == (is_sgn ? q_sx16 : q_ux16)) :
    (q == (is_sgn ? q_sx8 : q_ux8));

  // Multiply; the narrow forms keep the low half only
  wire [31:0] sprod = 32'($signed(a_n) * $signed(b_n));
  wire [31:0] uprod = {16'h0000, a_n} * {16'h0000, b_n};
  wire [31:0] prod = is_sgn ? sprod : uprod;

  // bit index is three bits, so only 0..7 of a half
  wire [7:0] mask8 = `CRF_BIT_ONE << ex.bit_idx;
  wire [7:0] bit8 = (ex.op == crf_pkg::bit_set_op) ?
    (a8 | mask8) : (a8 & ~mask8);

  // A pair destination must be the lower register of its pair
  wire bad_pair = is_wide && ex.word && ex.dst[1];
  wire fault = bad_pair || (is_div && (dvs_zero || !q_fit));
  wire ex_go = ex.valid && !fault;

  logic [15:0] next_dst;
  logic [15:0] next_up;
  logic wr_up;
  logic [7:0] r8;
  always_comb begin
    next_dst = dst16;
    next_up = up16;
    wr_up = 1'b0;
    r8 = is_bit ? bit8 : (is_div ? q[7:0] : prod[7:0]);
    if (!is_wide) begin
      if (ex.word && !is_bit) begin
        next_dst = is_div ? q[15:0] : prod[15:0];
      end else if (ex.hi) begin
        next_dst[15:8] = r8;
      end else begin
        next_dst[7:0] = r8;
      end
    // wide byte: product 16, or remainder and quotient
    end else if (!ex.word) begin
      next_dst = is_div ? {rem[7:0], q[7:0]} : prod[15:0];
    // wide word: upper half into the pair register
    end else begin
      next_dst = is_div ? q[15:0] : prod[15:0];
      next_up = is_div ? rem[15:0] : prod[31:16];
      wr_up = 1'b1;
    end
  end

  // Operations take the write path; a plain write in that cycle is not taken
  wire wr_take = wr.valid && !ex.valid;
  assign wr_ready = !ex.valid;
  wire w_long = (wr.size == crf_pkg::size_long);
  wire [2:0] w_lo = w_long ? (wr.idx & ~`CRF_PAIR_BIT) : wr.idx;
  wire [2:0] w_up = w_lo | `CRF_PAIR_BIT;
  wire [15:0] w_cur = dreg[bank_sel][w_lo];
  wire w_data = wr_take && (wr.kind == crf_pkg::kind_data);
  // byte writes leave the other half alone
  wire [15:0] w_val = (wr.size == crf_pkg::size_low) ?
    {w_cur[15:8], wr.data[7:0]} :
    (wr.size == crf_pkg::size_high) ? {wr.data[7:0], w_cur[7:0]} :
    wr.data[15:0];

  wire r_long = (rd.size == crf_pkg::size_long);
  wire [2:0] r_lo = r_long ? (rd.idx & ~`CRF_PAIR_BIT) : rd.idx;
  wire [15:0] r_lv = dreg[bank_sel][r_lo];
  wire [15:0] r_uv = dreg[bank_sel][r_lo | `CRF_PAIR_BIT];
  logic [31:0] rd_mux;
  always_comb begin
    case (rd.kind)
      crf_pkg::kind_data: begin
        case (rd.size)
          crf_pkg::size_low: rd_mux = {24'h000000, r_lv[7:0]};
          crf_pkg::size_high: rd_mux = {24'h000000, r_lv[15:8]};
          crf_pkg::size_word: rd_mux = {16'h0000, r_lv};
          default: rd_mux = {r_uv, r_lv};
        endcase
      end
      crf_pkg::kind_addr: rd_mux = areg[bank_sel][rd.idx[1:0]];
      crf_pkg::kind_frame: rd_mux = frame_base_pointer[bank_sel];
      crf_pkg::kind_static: rd_mux = static_base_pointer;
      crf_pkg::kind_flag: rd_mux = condition_word;
      default: rd_mux = `CRF_RST32;
    endcase
  end

  // every write goes to the selected bank only
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int b = 0; b < `CRF_BANKS; b++) begin
        for (int i = 0; i < `CRF_NDATA; i++) begin
          dreg[b][i] <= `CRF_RST16;
        end
      end
    end else if (ex_go) begin
      dreg[bank_sel][ex.dst] <= next_dst;
      if (wr_up) begin
        dreg[bank_sel][up_idx] <= next_up;
      end
    end else if (w_data) begin
      dreg[bank_sel][w_lo] <= w_val;
      if (w_long) begin
        dreg[bank_sel][w_up] <= wr.data[31:16];
      end
    end
  end

  // full 32-bit pointer and flag registers
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int b = 0; b < `CRF_BANKS; b++) begin
        frame_base_pointer[b] <= `CRF_RST32;
        for (int i = 0; i < `CRF_NADDR; i++) begin
          areg[b][i] <= `CRF_RST32;
        end
      end
      static_base_pointer <= `CRF_RST32;
      condition_word <= `CRF_RST32;
    end else if (wr_take) begin
      case (wr.kind)
        crf_pkg::kind_addr: areg[bank_sel][wr.idx[1:0]] <= wr.data;
        crf_pkg::kind_frame: frame_base_pointer[bank_sel] <= wr.data;
        crf_pkg::kind_static: static_base_pointer <= wr.data;
        crf_pkg::kind_flag: condition_word <= wr.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data <= `CRF_RST32;
      ex_result <= `CRF_RST32;
      ex_done <= 1'b0;
      ex_fault <= 1'b0;
    end else begin
      rd_data <= rd_mux;
      ex_done <= ex_go;
      ex_fault <= ex.valid && fault;
      if (ex.valid) begin
        ex_result <= {next_up, next_dst};
      end
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  wire lo_go = ex_go && !ex.word && !ex.hi && !is_wide;
  wire word_go = ex_go && ex.word && !is_wide;
  wire is_prod = ex.op inside {crf_pkg::signed_product_op,
    crf_pkg::unsigned_product_op};

  byte_div_a: assert property (
    lo_go && ex.op == crf_pkg::unsigned_quotient_op |=> ex_done &&
    ex_result[7:0] == $past(a8) / $past(b8) &&
    ex_result[15:8] == $past(dst16[15:8]))
    else $error("byte quotient wrong");
  word_div_a: assert property (
    word_go && ex.op == crf_pkg::unsigned_quotient_op |=>
    ex_result[15:0] == $past(dst16) / $past(src16))
    else $error("word quotient wrong");
  byte_prod_a: assert property (
    lo_go && is_prod |=> ex_result[7:0] == 8'($past(a8) * $past(b8)) &&
    ex_result[15:8] == $past(dst16[15:8]))
    else $error("byte product wrong");
  word_prod_a: assert property (
    word_go && is_prod |=>
    ex_result[15:0] == 16'($past(dst16) * $past(src16)))
    else $error("word product wrong");
  wide_prod_a: assert property (
    ex_go && ex.word && ex.op == crf_pkg::wide_unsigned_product_op |=>
    ex_result == $past(dst16) * $past(src16))
    else $error("wide product wrong");
  bit_high_a: assert property (
    ex_go && ex.hi && ex.op == crf_pkg::bit_set_op |=>
    ex_result[15:8] == ($past(dst16[15:8]) |
    (`CRF_BIT_ONE << $past(ex.bit_idx))) &&
    ex_result[7:0] == $past(dst16[7:0]))
    else $error("bit set wrong");
  half_write_a: assert property (
    w_data && wr.size == crf_pkg::size_high |=>
    dreg[$past(bank_sel)][$past(wr.idx)] ==
    {$past(wr.data[7:0]), $past(w_cur[7:0])})
    else $error("high half write wrong");
  pair_low_a: assert property (
    w_data && w_long && !wr.idx[2] |=>
    {dreg[$past(bank_sel)][{2'b01, $past(wr.idx[0])}],
    dreg[$past(bank_sel)][{2'b00, $past(wr.idx[0])}]} == $past(wr.data))
    else $error("low pair write wrong");
  pair_high_a: assert property (
    w_data && w_long && wr.idx[2] |=>
    {dreg[$past(bank_sel)][{2'b11, $past(wr.idx[0])}],
    dreg[$past(bank_sel)][{2'b10, $past(wr.idx[0])}]} == $past(wr.data))
    else $error("high pair write wrong");
  frame_wide_a: assert property (
    wr_take && wr.kind == crf_pkg::kind_frame |=> ##1
    rd_data == $past(wr.data, 2) || !($past(rd.kind) ==
    crf_pkg::kind_frame && $past(bank_sel, 2) == $past(bank_sel)))
    else $error("frame base not 32 bits");
  bank_keep_a: assert property (
    w_data && !w_long |=> dreg[!$past(bank_sel)][$past(wr.idx)] ==
    $past(dreg[!bank_sel][wr.idx]))
    else $error("other bank disturbed");
  flag_wide_a: assert property (
    wr_take && wr.kind == crf_pkg::kind_flag |=>
    condition_word == $past(wr.data))
    else $error("flag register write wrong");
  fault_flag_a: assert property (
    ex.valid && fault |=> ex_fault && !ex_done)
    else $error("fault not flagged");

  div_cov: cover property (ex_go && is_div && is_alt);
  fault_cov: cover property (ex.valid && is_div && dvs_zero);
  wide_cov: cover property (ex_go && is_wide && ex.word ##1 ex_done);
  bank_cov: cover property (w_data && w_long && bank_sel);
  pair_cov: cover property (ex.valid && bad_pair);
endmodule

// [tb/crf_core_bench.sv]
// Self-checking bench for the core register file
`timescale 1ns/1ps
module crf_core_bench;
  typedef struct {
    crf_pkg::crf_kind_e k;
    logic [2:0] i;
    crf_pkg::crf_size_e s;
    logic [31:0] d;
    logic [2:0] ri;
    crf_pkg::crf_size_e rs;
    logic [31:0] e;
  } crf_row_s;
  typedef struct {
    crf_pkg::crf_op_e op;
    logic w;
    logic h;
    logic [2:0] b;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
    logic [31:0] e;
  } crf_oprow_s;
  logic clock, rst, bank_sel, wr_ready, ex_done, ex_fault;
  crf_pkg::crf_wr_s wr;
  crf_pkg::crf_rd_s rd;
  crf_pkg::crf_ex_s ex;
  logic [31:0] rd_data, ex_result, condition_word;
  int errors, comparisons, cycles;
  // Later rows read back values left by earlier ones
  crf_row_s rows [11] = '{
    '{crf_pkg::kind_data,3'h0,crf_pkg::size_word,32'h1234,3'h0,
      crf_pkg::size_word,32'h1234},
    '{crf_pkg::kind_data,3'h0,crf_pkg::size_high,32'hAB,3'h0,
      crf_pkg::size_word,32'hAB34},
    '{crf_pkg::kind_data,3'h2,crf_pkg::size_word,32'h5678,3'h0,
      crf_pkg::size_long,32'h5678AB34},
    '{crf_pkg::kind_data,3'h1,crf_pkg::size_long,32'hCAFE0001,3'h3,
      crf_pkg::size_word,32'hCAFE},
    '{crf_pkg::kind_data,3'h3,crf_pkg::size_low,32'h5A,3'h3,
      crf_pkg::size_high,32'hCA},
    '{crf_pkg::kind_data,3'h5,crf_pkg::size_long,32'h11112222,3'h7,
      crf_pkg::size_word,32'h1111},
    '{crf_pkg::kind_data,3'h4,crf_pkg::size_long,32'h33334444,3'h6,
      crf_pkg::size_word,32'h3333},
    '{crf_pkg::kind_frame,3'h0,crf_pkg::size_long,32'h89ABCDEF,3'h0,
      crf_pkg::size_long,32'h89ABCDEF},
    '{crf_pkg::kind_addr,3'h3,crf_pkg::size_long,32'h01020304,3'h3,
      crf_pkg::size_long,32'h01020304},
    '{crf_pkg::kind_static,3'h0,crf_pkg::size_long,32'h55667788,3'h0,
      crf_pkg::size_long,32'h55667788},
    '{crf_pkg::kind_flag,3'h0,crf_pkg::size_long,32'hA5A5,3'h0,
      crf_pkg::size_long,32'hA5A5}};
  // Operands go to regs zero, one, two; result shows as {two, zero}
  crf_oprow_s ops [21] = '{
    '{crf_pkg::unsigned_product_op,0,0,0,'h7710,'h20,'h5678,'h56787700},
    '{crf_pkg::signed_product_op,0,0,0,'h33F0,'h9,'h5678,'h56783370},
    '{crf_pkg::unsigned_product_op,1,0,0,'h1234,'h10,'h5678,'h56782340},
    '{crf_pkg::signed_product_op,1,0,0,'hFFFE,'h3,'h5678,'h5678FFFA},
    '{crf_pkg::unsigned_quotient_op,0,0,0,'h5A64,'h7,'h5678,'h56785A0E},
    '{crf_pkg::signed_quotient_op,0,0,0,'hF9,'h2,'h5678,'h567800FD},
    '{crf_pkg::alt_sign_quotient_op,0,0,0,'hF9,'h2,'h5678,'h567800FC},
    '{crf_pkg::unsigned_quotient_op,1,0,0,'h1000,'h10,'h5678,'h56780100},
    '{crf_pkg::signed_quotient_op,1,0,0,'hFFF9,'h2,'h5678,'h5678FFFD},
    '{crf_pkg::alt_sign_quotient_op,1,0,0,'hFFF9,'h2,'h5678,'h5678FFFC},
    '{crf_pkg::bit_set_op,0,1,7,'h0,'h0,'h5678,'h56788000},
    '{crf_pkg::bit_set_op,0,0,7,'h100,'h0,'h5678,'h56780180},
    '{crf_pkg::bit_clear_op,0,1,0,'hFFFF,'h0,'h5678,'h5678FEFF},
    '{crf_pkg::unsigned_product_op,0,1,0,'h0312,'h0400,'h5678,'h56780C12},
    '{crf_pkg::wide_unsigned_product_op,0,0,0,'h12F0,'h10,'h5678,'h56780F00},
    '{crf_pkg::wide_unsigned_quotient_op,0,0,0,'h0123,'h10,'h5678,'h56780312},
    '{crf_pkg::wide_unsigned_product_op,1,0,0,'h1234,'h10,'h5678,'h12340},
    '{crf_pkg::wide_signed_product_op,1,0,0,'hFFFE,'h3,'h0,'hFFFFFFFA},
    '{crf_pkg::wide_unsigned_quotient_op,1,0,0,'h2340,'h10,'h1,'h1234},
    '{crf_pkg::wide_signed_quotient_op,1,0,0,'hFFF9,'h2,'hFFFF,'hFFFFFFFD},
    '{crf_pkg::wide_alt_sign_quotient_op,1,0,0,'hFFF9,'h2,'hFFFF,
      'h0001FFFC}};

  crf_core dut_u (.clock(clock), .rst(rst), .bank_sel(bank_sel), .wr(wr),
    .wr_ready(wr_ready), .rd(rd), .rd_data(rd_data), .ex(ex),
    .ex_result(ex_result), .ex_done(ex_done), .ex_fault(ex_fault),
    .condition_word(condition_word));

  task automatic chk(input string n, input logic [31:0] e,
      input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic put(input crf_pkg::crf_kind_e k, input logic [2:0] i,
      input crf_pkg::crf_size_e s, input logic [31:0] d);
    @(posedge clock);
    wr <= '{1'b1, k, i, s, d};
    @(posedge clock);
    wr.valid <= 1'b0;
  endtask
  task automatic get(input crf_pkg::crf_kind_e k, input logic [2:0] i,
      input crf_pkg::crf_size_e s, input logic [31:0] e, input string n);
    @(posedge clock);
    rd <= '{k, i, s};
    @(posedge clock);
    #1 chk(n, e, rd_data);
  endtask
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // A full run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      $display("[FAIL] run length expected 3000 seen more");
      report_and_stop;
    end
  end

  initial begin
    rst = 1'b1;
    bank_sel = 1'b0;
    wr = '0;
    rd = '0;
    ex = '0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    #1 chk("condition_word reset", 32'h0, condition_word);
    chk("ex flags reset", 32'h0, {ex_done, ex_fault});
    foreach (rows[n]) begin
      put(rows[n].k, rows[n].i, rows[n].s, rows[n].d);
      get(rows[n].k, rows[n].ri, rows[n].rs, rows[n].e,
        "reg read");
    end
    chk("condition_word", 32'hA5A5, condition_word);
    foreach (ops[n]) begin
      put(crf_pkg::kind_data, 3'h0, crf_pkg::size_word, {16'h0, ops[n].x});
      put(crf_pkg::kind_data, 3'h1, crf_pkg::size_word, {16'h0, ops[n].y});
      put(crf_pkg::kind_data, 3'h2, crf_pkg::size_word, {16'h0, ops[n].z});
      @(posedge clock);
      ex <= '{1'b1, ops[n].op, ops[n].w, ops[n].h, 3'h0, 3'h1, ops[n].b};
      @(posedge clock);
      ex.valid <= 1'b0;
      #1 chk("done and fault", 32'h2, {ex_done, ex_fault});
      chk("ex_result", ops[n].e,
        ex_result);
    end
    // Quotient overflow and a pair destination off its lower half fault
    put(crf_pkg::kind_data, 3'h0, crf_pkg::size_word, 32'h0080);
    put(crf_pkg::kind_data, 3'h1, crf_pkg::size_word, 32'h00FF);
    put(crf_pkg::kind_data, 3'h2, crf_pkg::size_word, 32'h0003);
    @(posedge clock);
    ex <= '{1'b1, crf_pkg::signed_quotient_op, 1'b0, 1'b0, 3'h0, 3'h1,
      3'h0};
    @(posedge clock);
    ex <= '{1'b1, crf_pkg::wide_unsigned_product_op, 1'b1, 1'b0, 3'h2,
      3'h1, 3'h0};
    #1 chk("overflow fault", 32'h1, {ex_done, ex_fault});
    @(posedge clock);
    ex.valid <= 1'b0;
    #1 chk("pair fault", 32'h1, {ex_done, ex_fault});
    get(crf_pkg::kind_data, 3'h0, crf_pkg::size_low, 32'h80,
      "reg zero low");
    get(crf_pkg::kind_data, 3'h2, crf_pkg::size_word, 32'h3,
      "reg two kept");
    // Zero divisor while a write is pending: neither lands
    put(crf_pkg::kind_data, 3'h0, crf_pkg::size_word, 32'h1111);
    put(crf_pkg::kind_data, 3'h1, crf_pkg::size_word, 32'h0);
    @(posedge clock);
    wr <= '{1'b1, crf_pkg::kind_data, 3'h0, crf_pkg::size_word, 32'hDEAD};
    ex <= '{1'b1, crf_pkg::unsigned_quotient_op, 1'b1, 1'b0, 3'h0, 3'h1,
      3'h0};
    #1 chk("wr_ready", 32'h0, wr_ready);
    @(posedge clock);
    wr.valid <= 1'b0;
    ex.valid <= 1'b0;
    #1 chk("zero divisor", 32'h1, {ex_done, ex_fault});
    get(crf_pkg::kind_data, 3'h0, crf_pkg::size_word, 32'h1111,
      "reg zero kept");
    @(posedge clock);
    bank_sel <= 1'b1;
    get(crf_pkg::kind_data, 3'h0, crf_pkg::size_word, 32'h0,
      "bank one reg zero");
    put(crf_pkg::kind_frame, 3'h0, crf_pkg::size_long, 32'hCAFEF00D);
    get(crf_pkg::kind_frame, 3'h0, crf_pkg::size_long, 32'hCAFEF00D,
      "frame base bank one");
    @(posedge clock);
    bank_sel <= 1'b0;
    get(crf_pkg::kind_frame, 3'h0, crf_pkg::size_long, 32'h89ABCDEF,
      "frame base bank zero");
    // Reset again in mid-run clears every register
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    #1 chk("condition_word rerst", 32'h0, condition_word);
    get(crf_pkg::kind_addr, 3'h3, crf_pkg::size_long, 32'h0,
      "addr three rerst");
    report_and_stop;
  end
endmodule
